// file: flash_prot_map.svh
// Address map, field positions, reset values and keys of the protection checker.
// Assumes byte addressing on the Avalon-MM register port.
`ifndef FLASH_PROT_MAP_SVH
`define FLASH_PROT_MAP_SVH
// Register byte offsets
`define OFS_OPT_KEY 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_MASK 8'h08
`define OFS_REGION_LOADED 8'h0c
`define OFS_OPT_REGION 8'h10
`define OFS_OPT_WP_MASK 8'h14
`define OFS_OPT_BOOT 8'h18
`define OFS_OTP_LOCK 8'h1c
// Status and mask bits
`define ST_WP_ERR 0
`define ST_PROT_ERR 1
`define ST_AUTO_ERASE 2
`define ST_UNLOCKED 3
`define ST_REGION_ON 4
`define ST_W 3
// Field positions
`define REGION_START_LSB 0
`define REGION_LAST_LSB 8
`define OTP_LOCK_LSB 0
`define OTP_DATA_LSB 16
// Option keys
`define OPT_KEY1 32'h08192a3b
`define OPT_KEY2 32'h4c5d6e7f
`define OTP_LOCK_VALUE 16'haa55
// Option reset (erased) values
`define RST_REGION_START 4'hf
`define RST_REGION_LAST 4'h0
`define RST_WP_MASK 8'h00
`define RST_BOOT_SIZE 3'h0
`define RST_OTP_LOCK 16'hffff
// Array geometry: byte offsets within the array
`define ADDR_W 15
`define SECTOR_LSB 12
`define SECTOR_MSB 14
`define PAGE2K_LSB 11
`define OTP_BASE 15'h0280
`define OTP_LAST 15'h02fc
`define OTP_WORD0 15'h0280
`endif

// file: flash_prot_pkg.sv
// Types shared by the protection checker.
// Assumes flash_prot_map.svh supplies the widths.
`include "flash_prot_map.svh"
package flash_prot_pkg;
  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_PROGRAM = 2'b01,
    OP_PAGE_ERASE = 2'b10,
    OP_MASS_ERASE = 2'b11
  } flash_op_t;
  typedef struct packed {
    logic valid;
    flash_op_t op;
    logic info;
    logic [`ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } access_req_t;
  typedef struct packed {
    logic ram_or_debug;
    logic [`ADDR_W-1:0] pc;
  } exec_ctx_t;
  typedef enum logic [1:0] {
    KEY_LOCKED = 2'b00,
    KEY_HALF = 2'b01,
    KEY_OPEN = 2'b10
  } key_state_t;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ERASE = 2'b01,
    SEQ_STORE = 2'b10
  } erase_seq_t;
endpackage : flash_prot_pkg

// file: flash_protection_checker.sv
// Protection checker in front of an embedded flash array.
// Assumes accesses and reload pulses come from logic on i_core_clk.
// Notes on behaviour
// - OTP page word zero holds lock halfword
// - OTP uses main procedure; mass erase spares
// - New lock value acts after next reload
// - Lock 0xAA55 allows read, refuses program/erase
// - Region spans start to last inclusive in 2K
// - Region active when start not above last
// - Disabling active region mass-erases, then stores
// - Loaded region register changes only on reload
// - Region access only when executing from inside
// - Each mask bit guards one 4K sector
// - Protected sector refuses program, erase, mass
// - Refused protected-sector write sets error flag
// - Sector mask ignores information area
// - Valid boot region refuses erase, flags error
// - Boot size change mass-erases main array
// - Option bytes write-protected until key sequence
// - Keys 0x08192A3B then 0x4C5D6E7F unlock
// - Mass erase ignores execution location
`timescale 1ns/1ps
`include "flash_prot_map.svh"
module flash_protection_checker (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Reload of option values (power-related or option-load reset)
  input wire logic i_opt_reload,
  // Flash access request and execution context
  input wire flash_prot_pkg::access_req_t i_acc,
  input wire flash_prot_pkg::exec_ctx_t i_exec,
  output logic o_acc_grant,
  output logic o_acc_deny,
  // Commands to the array
  output logic o_mass_erase,
  // Avalon-MM slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Interrupt
  output logic o_irq
);

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  // region page bounds
  function automatic logic in_region(input logic [`ADDR_W-1:0] a, input logic [3:0] s,
                                     input logic [3:0] l);
    logic [3:0] pg;
    pg = a[`ADDR_W-1:`PAGE2K_LSB];
    in_region = (s <= l) && (pg >= s) && (pg <= l);
  endfunction : in_region

  function automatic logic in_boot(input logic [`ADDR_W-1:0] a, input logic [2:0] sz);
    logic [3:0] pg;
    pg = a[`ADDR_W-1:`PAGE2K_LSB];
    in_boot = (sz != `RST_BOOT_SIZE) && ({1'b0, sz} > (4'hf - pg));
  endfunction : in_boot

  // ---------------------------------------------------------------
  // Stored option values and loaded copies
  // ---------------------------------------------------------------
  logic [3:0] opt_start_q, opt_last_q, ld_start_q, ld_last_q;
  logic [7:0] opt_wp_q, ld_wp_q;
  logic [2:0] opt_boot_q, pend_boot_q;
  logic [15:0] opt_lock_q, ld_lock_q;
  logic [3:0] pend_start_q, pend_last_q;
  logic pend_is_region_q;
  logic load_q;
  flash_prot_pkg::key_state_t key_q;
  flash_prot_pkg::erase_seq_t seq_q;
  logic [`ST_W-1:0] status_q, mask_q;
  logic ack_q;
  logic [31:0] rdata_q;

  logic bus_wr, bus_rd, region_on, unlocked;
  logic refuse_otp, refuse_region, refuse_wp, refuse_boot, is_write;
  logic new_region_off;

  assign unlocked = (key_q == flash_prot_pkg::KEY_OPEN);
  assign region_on = (ld_start_q <= ld_last_q);
  assign bus_wr = i_avs_write & ~ack_q;
  assign bus_rd = i_avs_read & ~ack_q;
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
  assign new_region_off =
    i_avs_writedata[`REGION_START_LSB+:4] > i_avs_writedata[`REGION_LAST_LSB+:4];

  // ---------------------------------------------------------------
  // Access decision
  // ---------------------------------------------------------------
  assign is_write = (i_acc.op != flash_prot_pkg::OP_READ);
  assign refuse_otp = i_acc.info && is_write && (i_acc.addr >= `OTP_BASE)
                      && (i_acc.addr <= `OTP_LAST) && (ld_lock_q == `OTP_LOCK_VALUE);
  assign refuse_region = !i_acc.info && (i_acc.op != flash_prot_pkg::OP_MASS_ERASE)
                         && in_region(i_acc.addr, ld_start_q, ld_last_q)
                         && (i_exec.ram_or_debug
                             || !in_region(i_exec.pc, ld_start_q, ld_last_q));
  always_comb
  begin
    refuse_wp = 1'b0;
    if (!i_acc.info && is_write)
    begin
      // any mask bit blocks mass erase
      if (i_acc.op == flash_prot_pkg::OP_MASS_ERASE)
        refuse_wp = (ld_wp_q != `RST_WP_MASK);
      else
        refuse_wp = ld_wp_q[i_acc.addr[`SECTOR_MSB:`SECTOR_LSB]];
    end
  end
  assign refuse_boot = !i_acc.info && (i_acc.op == flash_prot_pkg::OP_PAGE_ERASE)
                       && in_boot(i_acc.addr, opt_boot_q);
  assign o_acc_deny = i_acc.valid & (refuse_otp | refuse_region | refuse_wp | refuse_boot
                      | (i_acc.info && i_acc.op == flash_prot_pkg::OP_MASS_ERASE));
  assign o_acc_grant = i_acc.valid & ~o_acc_deny;

  // ---------------------------------------------------------------
  // Option key sequence
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      key_q <= flash_prot_pkg::KEY_LOCKED;
    else if (i_opt_reload)
      key_q <= flash_prot_pkg::KEY_LOCKED;
    else if (bus_wr && i_avs_address == `OFS_OPT_KEY)
    begin
      unique case (key_q)
        flash_prot_pkg::KEY_LOCKED:
          key_q <= (i_avs_writedata == `OPT_KEY1) ? flash_prot_pkg::KEY_HALF
                                                  : flash_prot_pkg::KEY_LOCKED;
        flash_prot_pkg::KEY_HALF:
          key_q <= (i_avs_writedata == `OPT_KEY2) ? flash_prot_pkg::KEY_OPEN
                                                  : flash_prot_pkg::KEY_LOCKED;
        flash_prot_pkg::KEY_OPEN:
          key_q <= flash_prot_pkg::KEY_LOCKED;
        default:
          key_q <= flash_prot_pkg::KEY_LOCKED;
      endcase
    end
    else if (bus_wr)
      key_q <= (key_q == flash_prot_pkg::KEY_HALF) ? flash_prot_pkg::KEY_LOCKED : key_q;
  end

  // ---------------------------------------------------------------
  // Automatic mass erase, then option store
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      seq_q <= flash_prot_pkg::SEQ_IDLE;
      pend_start_q <= `RST_REGION_START;
      pend_last_q <= `RST_REGION_LAST;
      pend_boot_q <= `RST_BOOT_SIZE;
      pend_is_region_q <= 1'b0;
    end
    else
    begin
      unique case (seq_q)
        flash_prot_pkg::SEQ_IDLE:
          if (bus_wr && unlocked)
          begin
            if (i_avs_address == `OFS_OPT_REGION && region_on && new_region_off)
            begin
              seq_q <= flash_prot_pkg::SEQ_ERASE;
              pend_is_region_q <= 1'b1;
              pend_start_q <= i_avs_writedata[`REGION_START_LSB+:4];
              pend_last_q <= i_avs_writedata[`REGION_LAST_LSB+:4];
            end
            else if (i_avs_address == `OFS_OPT_BOOT && i_avs_writedata[2:0] != opt_boot_q)
            begin
              seq_q <= flash_prot_pkg::SEQ_ERASE;
              pend_is_region_q <= 1'b0;
              pend_boot_q <= i_avs_writedata[2:0];
            end
          end
        flash_prot_pkg::SEQ_ERASE:
          seq_q <= flash_prot_pkg::SEQ_STORE;
        flash_prot_pkg::SEQ_STORE:
          seq_q <= flash_prot_pkg::SEQ_IDLE;
        default:
          seq_q <= flash_prot_pkg::SEQ_IDLE;
      endcase
    end
  end
  // erase covers region and boot area; OTP untouched
  assign o_mass_erase = (seq_q == flash_prot_pkg::SEQ_ERASE);

  // ---------------------------------------------------------------
  // Option bytes
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      opt_start_q <= `RST_REGION_START;
      opt_last_q <= `RST_REGION_LAST;
      opt_wp_q <= `RST_WP_MASK;
      opt_boot_q <= `RST_BOOT_SIZE;
    end
    else if (seq_q == flash_prot_pkg::SEQ_STORE)
    begin
      if (pend_is_region_q)
      begin
        opt_start_q <= pend_start_q;
        opt_last_q <= pend_last_q;
      end
      else
        opt_boot_q <= pend_boot_q;
    end
    else if (bus_wr && unlocked && seq_q == flash_prot_pkg::SEQ_IDLE)
    begin
      if (i_avs_address == `OFS_OPT_REGION && !(region_on && new_region_off))
      begin
        opt_start_q <= i_avs_writedata[`REGION_START_LSB+:4];
        opt_last_q <= i_avs_writedata[`REGION_LAST_LSB+:4];
      end
      if (i_avs_address == `OFS_OPT_WP_MASK)
        opt_wp_q <= i_avs_writedata[7:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      opt_lock_q <= `RST_OTP_LOCK;
    else if (o_acc_grant && i_acc.info && i_acc.addr == `OTP_WORD0
             && i_acc.op == flash_prot_pkg::OP_PROGRAM)
      opt_lock_q <= i_acc.wdata[`OTP_LOCK_LSB+:16];
    else if (o_acc_grant && i_acc.info && i_acc.op == flash_prot_pkg::OP_PAGE_ERASE
             && i_acc.addr >= `OTP_BASE && i_acc.addr <= `OTP_LAST)
      opt_lock_q <= `RST_OTP_LOCK;
  end

  // ---------------------------------------------------------------
  // Loaded copies, refreshed only at reload
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      load_q <= 1'b1;
    else
      load_q <= 1'b0;
  end

  // lock acts after reload; region reload only
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ld_start_q <= `RST_REGION_START;
      ld_last_q <= `RST_REGION_LAST;
      ld_wp_q <= `RST_WP_MASK;
      ld_lock_q <= `RST_OTP_LOCK;
    end
    else if (load_q || i_opt_reload)
    begin
      ld_start_q <= opt_start_q;
      ld_last_q <= opt_last_q;
      ld_wp_q <= opt_wp_q;
      ld_lock_q <= opt_lock_q;
    end
  end

  // ---------------------------------------------------------------
  // Status, mask and interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      status_q <= '0;
    else
    begin
      if (bus_rd && i_avs_address == `OFS_STATUS)
        status_q <= '0;
      // sector error flag, set wins over clear
      if (i_acc.valid && refuse_wp)
        status_q[`ST_WP_ERR] <= 1'b1;
      if (i_acc.valid && refuse_boot)
        status_q[`ST_PROT_ERR] <= 1'b1;
      if (o_mass_erase)
        status_q[`ST_AUTO_ERASE] <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      mask_q <= '0;
    else if (bus_wr && i_avs_address == `OFS_IRQ_MASK)
      mask_q <= i_avs_writedata[`ST_W-1:0];
  end

  assign o_irq = |(status_q & mask_q);

  // ---------------------------------------------------------------
  // Register reads, one wait state
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      ack_q <= 1'b0;
    else
      ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      rdata_q <= '0;
    else if (bus_rd)
    begin
      rdata_q <= '0;
      unique case (i_avs_address)
        `OFS_STATUS:
          rdata_q <= {27'h0, region_on, unlocked, status_q};
        `OFS_IRQ_MASK:
          rdata_q <= {29'h0, mask_q};
        `OFS_REGION_LOADED:
          rdata_q <= {20'h0, ld_last_q, 4'h0, ld_start_q};
        `OFS_OPT_REGION:
          rdata_q <= {20'h0, opt_last_q, 4'h0, opt_start_q};
        `OFS_OPT_WP_MASK:
          rdata_q <= {24'h0, opt_wp_q};
        `OFS_OPT_BOOT:
          rdata_q <= {29'h0, opt_boot_q};
        `OFS_OTP_LOCK:
          rdata_q <= {16'h0, ld_lock_q};
        default:
          rdata_q <= '0;
      endcase
    end
  end
  assign o_avs_readdata = rdata_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_otp_lock;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (i_acc.valid && i_acc.info && i_acc.op == flash_prot_pkg::OP_PROGRAM
     && i_acc.addr == `OTP_BASE && ld_lock_q == `OTP_LOCK_VALUE) |-> o_acc_deny;
  endproperty
  a_otp_lock: assert property (p_otp_lock) else $error("locked OTP program granted");

  property p_lock_delay;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (!load_q && !i_opt_reload) |=> $stable(ld_lock_q) && $stable(ld_start_q);
  endproperty
  a_lock_delay: assert property (p_lock_delay) else $error("loaded value moved early");

  property p_region_exec;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (i_acc.valid && !i_acc.info && i_exec.ram_or_debug && region_on
     && i_acc.op != flash_prot_pkg::OP_MASS_ERASE
     && in_region(i_acc.addr, ld_start_q, ld_last_q)) |-> !o_acc_grant;
  endproperty
  a_region_exec: assert property (p_region_exec) else $error("region open to debug");

  property p_wp_mass;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (i_acc.valid && !i_acc.info && i_acc.op == flash_prot_pkg::OP_MASS_ERASE
     && ld_wp_q != `RST_WP_MASK) |-> o_acc_deny ##1 status_q[`ST_WP_ERR];
  endproperty
  a_wp_mass: assert property (p_wp_mass) else $error("mass erase with sector locked");

  property p_wp_info;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (i_acc.valid && i_acc.info && ld_lock_q != `OTP_LOCK_VALUE
     && i_acc.op == flash_prot_pkg::OP_PROGRAM) |-> o_acc_grant;
  endproperty
  a_wp_info: assert property (p_wp_info) else $error("info program refused");

  property p_erase_then_store;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    $rose(o_mass_erase) |-> $stable(opt_start_q) ##1 !o_mass_erase ##1 !o_mass_erase;
  endproperty
  a_erase_then_store: assert property (p_erase_then_store) else $error("store before erase");

  property p_locked_opt;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (bus_wr && !unlocked && seq_q == flash_prot_pkg::SEQ_IDLE) |=> $stable(opt_wp_q);
  endproperty
  a_locked_opt: assert property (p_locked_opt) else $error("option written while locked");

  property p_boot_erase;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (i_acc.valid && refuse_boot) |-> o_acc_deny ##1 status_q[`ST_PROT_ERR];
  endproperty
  a_boot_erase: assert property (p_boot_erase) else $error("boot erase not flagged");

  c_unlock: cover property (@(posedge i_core_clk) disable iff (!i_rst_b) $rose(unlocked));
  c_auto_erase: cover property (@(posedge i_core_clk) disable iff (!i_rst_b) o_mass_erase);
  c_irq: cover property (@(posedge i_core_clk) disable iff (!i_rst_b) $rose(o_irq));

endmodule : flash_protection_checker

// file: cpu_access_model.sv
// Processor-side model that issues flash accesses with an execution context.
// Assumes the checker answers grant or deny in the cycle the request is held.
`timescale 1ns/1ps
module cpu_access_model (
  // Clock
  input wire logic i_core_clk,
  // Answer from the checker
  input wire logic i_grant,
  input wire logic i_deny,
  // Request and context
  output flash_prot_pkg::access_req_t o_acc,
  output flash_prot_pkg::exec_ctx_t o_exec
);
  initial
  begin
    o_acc = '0;
    o_exec = '0;
  end

  task automatic issue(input flash_prot_pkg::flash_op_t op, input logic info,
                       input logic [14:0] addr, input logic [15:0] ctx,
                       output logic [1:0] ans);
    @(posedge i_core_clk);
    o_acc <= {1'b1, op, info, addr, 32'h1234aa55};
    o_exec <= ctx;
    @(posedge i_core_clk);
    ans = {i_grant, i_deny};
    // Released lines show the inverse of the last address, data and context; op and info keep their value
    o_acc <= {1'b0, op, info, ~addr, 32'hedcb55aa};
    o_exec <= ~ctx;
  endtask : issue
endmodule : cpu_access_model

// file: testbench.sv
// Self-checking bench for the flash protection checker.
// Assumes the design, its package and the processor model are compiled first.
`timescale 1ns/1ps
`include "flash_prot_map.svh"
module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic core_clk;
  logic rst_b;
  logic opt_reload;
  logic grant;
  logic deny;
  logic mass_erase;
  logic irq;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  flash_prot_pkg::access_req_t acc;
  flash_prot_pkg::exec_ctx_t exec_ctx;
  int err_total;
  int n_compared;
  int n_me;
  int cyc;
  localparam flash_prot_pkg::flash_op_t op_rd = flash_prot_pkg::OP_READ;
  localparam flash_prot_pkg::flash_op_t op_pg = flash_prot_pkg::OP_PROGRAM;
  localparam flash_prot_pkg::flash_op_t op_pe = flash_prot_pkg::OP_PAGE_ERASE;
  localparam flash_prot_pkg::flash_op_t op_me = flash_prot_pkg::OP_MASS_ERASE;

  flash_protection_checker uut (
    .i_core_clk(core_clk), .i_rst_b(rst_b), .i_opt_reload(opt_reload),
    .i_acc(acc), .i_exec(exec_ctx), .o_acc_grant(grant), .o_acc_deny(deny),
    .o_mass_erase(mass_erase), .i_avs_address(avs_address), .i_avs_read(avs_read),
    .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
    .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest), .o_irq(irq)
  );

  cpu_access_model cpu (
    .i_core_clk(core_clk), .i_grant(grant), .i_deny(deny), .o_acc(acc), .o_exec(exec_ctx)
  );

  // ----------------------------------------
  // Clock, timeout and erase monitor
  // ----------------------------------------
  always #25 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    if (mass_erase === 1'b1)
      n_me <= n_me + 1;
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      err_total++;
      results();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge core_clk);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    // Only the bench timeout ends a wait that never sees the answer
    do
    begin
      @(posedge core_clk);
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rc

  task automatic ac(input flash_prot_pkg::flash_op_t op, input logic info,
                    input logic [14:0] a, input logic [15:0] ctx, input logic g);
    logic [1:0] ans;
    cpu.issue(op, info, a, ctx, ans);
    chk({30'h0, ans}, {30'h0, g, ~g});
  endtask : ac

  task automatic ck_irq(input logic e);
    repeat (2) @(negedge core_clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : ck_irq

  task automatic reload();
    @(posedge core_clk);
    opt_reload <= 1'b1;
    @(posedge core_clk);
    opt_reload <= 1'b0;
  endtask : reload

  task automatic unlock();
    wr(8'h00, `OPT_KEY1);
    wr(8'h00, `OPT_KEY2);
  endtask : unlock

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_values();
    logic [7:0] a[9];
    logic [31:0] e[9];
    a = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
    e = '{32'h0, 32'h0, 32'h0, 32'h0f, 32'h0f, 32'h0, 32'h0, 32'hffff, 32'h0};
    for (int i = 0; i < 9; i++)
      rc(a[i], e[i]);
    ck_irq(1'b0);
  endtask : t_reset_values

  task automatic t_key_sequence();
    wr(8'h10, 32'h0302);
    rc(8'h10, 32'h0f);
    wr(8'h00, `OPT_KEY1);
    wr(8'h08, 32'h0);
    wr(8'h00, `OPT_KEY2);
    rc(8'h04, 32'h0);
    unlock();
    rc(8'h04, 32'h08);
  endtask : t_key_sequence

  task automatic t_region();
    wr(8'h10, 32'h0302);
    rc(8'h10, 32'h0302);
    rc(8'h0c, 32'h0f);
    reload();
    rc(8'h0c, 32'h0302);
    rc(8'h04, 32'h10);
    ac(op_rd, 1'b0, 15'h0fff, 16'h0000, 1'b1);
    ac(op_rd, 1'b0, 15'h1000, 16'h0000, 1'b0);
    ac(op_pg, 1'b0, 15'h1ffc, 16'h0000, 1'b0);
    ac(op_pe, 1'b0, 15'h2000, 16'h0000, 1'b1);
    ac(op_rd, 1'b0, 15'h1000, 16'h1800, 1'b1);
    ac(op_pe, 1'b0, 15'h1ffc, 16'h1000, 1'b1);
    ac(op_rd, 1'b0, 15'h1000, 16'h9800, 1'b0);
    ac(op_me, 1'b0, 15'h0000, 16'h0000, 1'b1);
  endtask : t_region

  task automatic t_auto_erase();
    int me0;
    me0 = n_me;
    unlock();
    wr(8'h08, 32'h4);
    wr(8'h10, 32'h0105);
    repeat (4) @(posedge core_clk);
    chk(n_me, me0 + 1);
    rc(8'h10, 32'h0105);
    rc(8'h0c, 32'h0302);
    ck_irq(1'b1);
    rc(8'h04, 32'h1c);
    ck_irq(1'b0);
    wr(8'h18, 32'h2);
    repeat (4) @(posedge core_clk);
    chk(n_me, me0 + 2);
    rc(8'h18, 32'h2);
    rc(8'h04, 32'h1c);
    wr(8'h00, 32'h0);
    wr(8'h10, 32'h0);
    rc(8'h10, 32'h0105);
    reload();
    rc(8'h04, 32'h0);
  endtask : t_auto_erase

  task automatic t_sector_wp();
    unlock();
    wr(8'h14, 32'h01);
    wr(8'h00, 32'h0);
    reload();
    wr(8'h08, 32'h4);
    ac(op_pg, 1'b0, 15'h0000, 16'h0000, 1'b0);
    ac(op_pe, 1'b0, 15'h0ffc, 16'h0000, 1'b0);
    ac(op_pg, 1'b0, 15'h1000, 16'h0000, 1'b1);
    ac(op_rd, 1'b0, 15'h0004, 16'h0000, 1'b1);
    ac(op_me, 1'b0, 15'h0000, 16'h0000, 1'b0);
    ac(op_pg, 1'b1, 15'h0284, 16'h0000, 1'b1);
    ck_irq(1'b0);
    wr(8'h08, 32'h1);
    ck_irq(1'b1);
    rc(8'h04, 32'h01);
    ck_irq(1'b0);
    ac(op_pe, 1'b0, 15'h7000, 16'h0000, 1'b0);
    ac(op_rd, 1'b0, 15'h7ffc, 16'h0000, 1'b1);
    ac(op_pe, 1'b0, 15'h6ffc, 16'h0000, 1'b1);
    rc(8'h04, 32'h02);
  endtask : t_sector_wp

  task automatic t_otp();
    ac(op_pg, 1'b1, 15'h0280, 16'h0000, 1'b1);
    rc(8'h1c, 32'hffff);
    reload();
    rc(8'h1c, 32'haa55);
    ac(op_pg, 1'b1, 15'h0284, 16'h0000, 1'b0);
    ac(op_pe, 1'b1, 15'h0280, 16'h0000, 1'b0);
    ac(op_rd, 1'b1, 15'h02fc, 16'h0000, 1'b1);
    ac(op_me, 1'b1, 15'h0000, 16'h0000, 1'b0);
    unlock();
    wr(8'h18, 32'h3);
    reload();
    rc(8'h1c, 32'haa55);
  endtask : t_otp

  task automatic results();
    $display("compared=%0d mismatches=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    opt_reload = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    err_total = 0;
    n_compared = 0;
    n_me = 0;
    cyc = 0;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset_values();
    t_key_sequence();
    t_region();
    t_auto_erase();
    t_sector_wp();
    t_otp();
    results();
  end
endmodule : testbench
